// ---- hw/owc_pkg.sv ----
// Shared constants and types for the oscillator warm-up counter block
package owc_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OWC_OFS_CTRL    = 8'h00; // warmup_control_reg
  localparam logic [7:0] OWC_OFS_CMP     = 8'h04; // warmup_compare_reg
  localparam logic [7:0] OWC_OFS_SYS1    = 8'h08; // system_control_one
  localparam logic [7:0] OWC_OFS_SYS2    = 8'h0c; // system_control_two
  localparam logic [7:0] OWC_OFS_STAT    = 8'h10; // counter and phase status

  // Field positions in warmup_control_reg
  localparam int OWC_CTRL_SEL    = 0;  // Source select, 0 high, 1 low
  localparam int OWC_CTRL_DIV_LO = 1;  // Divide field, two bits
  localparam int OWC_CTRL_ABORT  = 3;  // Abort, self clearing
  localparam int OWC_CTRL_BUSY   = 4;  // Software warm-up running, read only

  // Field positions in system_control_one / two
  localparam int OWC_SYS1_STOP   = 0;  // Enter STOP
  localparam int OWC_SYS2_FEN    = 0;  // Fast oscillator enable
  localparam int OWC_SYS2_SEN    = 1;  // Slow oscillator enable
  localparam int OWC_SYS2_SYSCK  = 2;  // Main clock from slow oscillator

  // Values after reset
  localparam logic       OWC_RST_SEL   = 1'b0;
  localparam logic [1:0] OWC_RST_DIV   = 2'b11;
  localparam logic [7:0] OWC_RST_CMP   = 8'h66;
  localparam logic       OWC_RST_FEN   = 1'b1;
  localparam logic       OWC_RST_SEN   = 1'b0;
  localparam logic       OWC_RST_SYSCK = 1'b0;

  // Counter geometry
  localparam int OWC_CNT_W  = 14; // Counter stages
  localparam int OWC_CMP_LO = 6;  // Lowest compared counter bit
  localparam int OWC_PRE_W  = 3;  // Prescaler stages

  // Warm-up phases
  typedef enum logic [1:0] {
    OWC_PH_POR_WARM,
    OWC_PH_RUN,
    OWC_PH_STOP,
    OWC_PH_STOP_WARM
  } owc_phase_t;

  // Operating modes reported out
  typedef enum logic [2:0] {
    OWC_SINGLE_OSC_NORMAL,
    OWC_DUAL_OSC_NORMAL,
    OWC_LOW_SPEED_FAST_OFF,
    OWC_LOW_SPEED_FAST_ON,
    OWC_STOP
  } owc_mode_t;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } owc_apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } owc_apb_rsp_t;

  // Oscillator and reset controls toward the chip
  typedef struct packed {
    logic fast_osc_enable;
    logic slow_osc_enable;
    logic main_clk_slow;
    logic slow_pins_gpio;
    logic core_reset_n;
  } owc_sys_out_t;

endpackage

// ---- hw/owc_top.sv ----
// Oscillator warm-up counter with start, stop, abort and mode control
//
// Notes on behaviour
// - After power-on, only counter runs; CPU held.
// - Reset clears source select, divide becomes 11.
// - Released counter counts high-frequency clock immediately.
// - Upper-bit match ends reset warm-up, releases CPU.
// - Compare register resets to 0x66.
// - STOP release uses clock that drove main.
// - After STOP, match stops counter, execution resumes.
// - Divide codes select by 1, 2, 4, 8.
// - STOP during software warm-up freezes, then resumes.
// - Source select: 0 high, 1 low frequency.
// - Enabling stopped oscillator starts counting.
// - Software warm-up match: interrupt, stop, clear.
// - Abort halts, clears counter, self clears.
// - Abort leaves enable bits untouched.
// - Only a 0-to-1 enable change starts counting.
// - Software warm-up covers single-to-dual, slow-fast-off-to-on.
// - Five modes: single, dual, two low-speed, STOP via registers.
// - Single mode frees slow oscillator pins.
// - Reset release enters single-oscillator normal mode.
// - Source mux, three-stage prescaler, 14-stage counter.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps

module owc_top
(
  // Clock and reset
  input  wire  logic                  pclk,
  input  wire  logic                  presetn,
  // APB slave
  input  wire  owc_pkg::owc_apb_req_t apb_req,
  output owc_pkg::owc_apb_rsp_t       apb_rsp,
  // Oscillator outputs and STOP release, asynchronous pins
  input  wire  logic                  high_freq_clock,
  input  wire  logic                  low_freq_clock,
  input  wire  logic                  stop_release,
  // Controls toward the chip
  output owc_pkg::owc_sys_out_t       sys_out,
  output owc_pkg::owc_mode_t          op_mode,
  output logic                        warmup_done_irq,
  output logic                        stop_resume
);
  import owc_pkg::*;

  localparam int NPIN = 3; // Synchronised pins

  // Pin synchroniser stages and filtered levels
  logic [NPIN-1:0] pin_raw;        // Raw pins
  logic [NPIN-1:0] sync1;          // First stage, read only by sync2
  logic [NPIN-1:0] sync2;          // Second stage
  logic [NPIN-1:0] sync3;          // Third stage
  logic [NPIN-1:0] filt;           // Accepted level
  logic [NPIN-1:0] filt_d;         // Accepted level, delayed
  logic [NPIN-1:0] rise;           // Accepted rising edge

  // Registers
  logic                  sel;        // Source select
  logic [1:0]            div;        // Divide code
  logic                  abort;      // Abort bit, reads 1 for one cycle
  logic [7:0]            cmp;        // Compare value
  logic                  stop_req;   // STOP bit
  logic                  fast_en;    // Fast oscillator enable
  logic                  slow_en;    // Slow oscillator enable
  logic                  sysck;      // Main clock select
  // Warm-up state
  owc_phase_t            phase;      // Current phase
  logic                  soft_act;   // Software warm-up running
  logic                  stop_src;   // Main clock source at STOP entry
  logic [OWC_PRE_W-1:0]  pre;        // Prescaler
  logic [OWC_CNT_W-1:0]  cnt;        // Warm-up counter
  // Decode
  logic                  wr_acc;     // Write in access phase
  logic                  setup;      // Setup phase
  logic                  wr_ctrl;    // Write to control
  logic                  wr_sys1;    // Write to system control one
  logic                  wr_sys2;    // Write to system control two
  logic                  abort_w;    // Abort written
  logic                  soft_start; // Enable rose
  logic                  counting;   // Counter allowed to step
  logic                  match;      // Upper bits equal compare
  logic                  src_rise;   // Selected source edge
  logic [OWC_PRE_W-1:0]  pre_mask;   // Prescaler terminal mask
  logic                  tick;       // Divided clock edge
  logic                  rel_go;     // STOP released
  logic [31:0]           next_rdata; // Read data for capture
  logic                  next_err;   // Error for capture

  assign pin_raw = {stop_release, low_freq_clock, high_freq_clock};

  // Three-stage synchroniser per pin; level accepted when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < NPIN; g++)
    begin : g_pin
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync1[g]  <= 1'b0;
          sync2[g]  <= 1'b0;
          sync3[g]  <= 1'b0;
          filt[g]   <= 1'b0;
          filt_d[g] <= 1'b0;
        end
        else
        begin
          sync1[g]  <= pin_raw[g];
          sync2[g]  <= sync1[g];
          sync3[g]  <= sync2[g];
          filt[g]   <= (sync2[g] == sync3[g]) ? sync3[g] : filt[g];
          filt_d[g] <= filt[g];
        end
      end
      assign rise[g] = filt[g] & ~filt_d[g];
    end
  endgenerate

  // Bus decode
  assign setup   = apb_req.psel & ~apb_req.penable;
  assign wr_acc  = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign wr_ctrl = wr_acc && (apb_req.paddr == OWC_OFS_CTRL);
  assign wr_sys1 = wr_acc && (apb_req.paddr == OWC_OFS_SYS1);
  assign wr_sys2 = wr_acc && (apb_req.paddr == OWC_OFS_SYS2);
  assign abort_w = wr_ctrl && apb_req.pwdata[OWC_CTRL_ABORT];

  // Start only on a 0-to-1 change of an enable, never on rewriting 1
  assign soft_start = wr_sys2 && (phase == OWC_PH_RUN) &&
    ((apb_req.pwdata[OWC_SYS2_FEN] && !fast_en) ||
     (apb_req.pwdata[OWC_SYS2_SEN] && !slow_en));

  // Source mux: reset uses high clock, STOP uses main clock source, else select bit
  always_comb
  begin
    case (phase)
      OWC_PH_POR_WARM:  src_rise = rise[0];
      OWC_PH_STOP_WARM: src_rise = stop_src ? rise[1] : rise[0];
      default:          src_rise = sel ? rise[1] : rise[0];
    endcase
  end

  // Prescaler tap: divided edge when the low div bits are all ones
  assign pre_mask = OWC_PRE_W'((1 << div) - 1);
  assign tick     = src_rise && ((pre & pre_mask) == pre_mask);

  // Counting gate; a frozen software warm-up waits in STOP
  assign counting = (phase == OWC_PH_POR_WARM) || (phase == OWC_PH_STOP_WARM) ||
                    ((phase == OWC_PH_RUN) && soft_act);
  assign match    = counting && (cnt[OWC_CNT_W-1:OWC_CMP_LO] == cmp);
  assign rel_go   = (phase == OWC_PH_STOP) && rise[2];

  // Control register, abort bit self clears after one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel   <= OWC_RST_SEL;
      div   <= OWC_RST_DIV;
      abort <= 1'b0;
    end
    else
    begin
      abort <= abort_w;
      if (wr_ctrl)
      begin
        sel <= apb_req.pwdata[OWC_CTRL_SEL];
        div <= apb_req.pwdata[OWC_CTRL_DIV_LO +: 2];
      end
    end
  end

  // Compare register, set by software before STOP or enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp <= OWC_RST_CMP;
    end
    else if (wr_acc && (apb_req.paddr == OWC_OFS_CMP))
    begin
      cmp <= apb_req.pwdata[7:0];
    end
  end

  // System control registers; abort never touches the enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fast_en <= OWC_RST_FEN;
      slow_en <= OWC_RST_SEN;
      sysck   <= OWC_RST_SYSCK;
    end
    else if (wr_sys2)
    begin
      fast_en <= apb_req.pwdata[OWC_SYS2_FEN];
      slow_en <= apb_req.pwdata[OWC_SYS2_SEN];
      sysck   <= apb_req.pwdata[OWC_SYS2_SYSCK];
    end
  end

  // Phase machine: reset warm-up, run, STOP, STOP warm-up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase    <= OWC_PH_POR_WARM;
      stop_req <= 1'b0;
      stop_src <= 1'b0;
    end
    else
    begin
      case (phase)
        OWC_PH_POR_WARM:  phase <= match ? OWC_PH_RUN : phase;
        OWC_PH_RUN:
        begin
          if (wr_sys1 && apb_req.pwdata[OWC_SYS1_STOP])
          begin
            phase    <= OWC_PH_STOP;
            stop_req <= 1'b1;
            stop_src <= sysck;
          end
        end
        OWC_PH_STOP:
        begin
          if (rel_go)
          begin
            // Frozen software warm-up resumes instead of a fresh one
            phase <= soft_act ? OWC_PH_RUN : OWC_PH_STOP_WARM;
            stop_req <= stop_req && !soft_act;
          end
        end
        default:
        begin
          if (match)
          begin
            phase    <= OWC_PH_RUN;
            stop_req <= 1'b0;
          end
        end
      endcase
    end
  end

  // Software warm-up flag; a start in the same cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      soft_act <= 1'b0;
    end
    else if (soft_start)
    begin
      soft_act <= 1'b1;
    end
    else if (abort_w || (match && (phase == OWC_PH_RUN)))
    begin
      soft_act <= 1'b0;
    end
  end

  // Prescaler and counter; cleared on start, abort, match and fresh STOP warm-up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre <= '0;
      cnt <= '0;
    end
    else if (soft_start || abort_w || match || (rel_go && !soft_act))
    begin
      pre <= '0;
      cnt <= '0;
    end
    else if (counting && src_rise)
    begin
      pre <= pre + 1'b1;
      cnt <= cnt + OWC_CNT_W'(tick);
    end
  end

  // Event pulses and chip controls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      warmup_done_irq <= 1'b0;
      stop_resume     <= 1'b0;
      sys_out         <= '0;
      op_mode         <= OWC_SINGLE_OSC_NORMAL;
    end
    else
    begin
      warmup_done_irq         <= match && (phase == OWC_PH_RUN);
      stop_resume             <= match && (phase == OWC_PH_STOP_WARM);
      sys_out.core_reset_n    <= sys_out.core_reset_n |
                                 ((phase == OWC_PH_POR_WARM) && match);
      sys_out.fast_osc_enable <= (phase == OWC_PH_POR_WARM) ||
                                 ((phase == OWC_PH_STOP_WARM) && !stop_src) ||
                                 ((phase == OWC_PH_RUN) && fast_en);
      sys_out.slow_osc_enable <= ((phase == OWC_PH_STOP_WARM) && stop_src) ||
                                 ((phase == OWC_PH_RUN) && slow_en);
      sys_out.main_clk_slow   <= sysck;
      sys_out.slow_pins_gpio  <= !slow_en;
      op_mode <= ((phase == OWC_PH_STOP) || (phase == OWC_PH_STOP_WARM)) ? OWC_STOP :
                 !sysck ? (slow_en ? OWC_DUAL_OSC_NORMAL : OWC_SINGLE_OSC_NORMAL) :
                 (fast_en ? OWC_LOW_SPEED_FAST_ON : OWC_LOW_SPEED_FAST_OFF);
    end
  end

  // Read mux, evaluated in the setup phase
  always_comb
  begin
    next_rdata = '0;
    next_err   = 1'b0;
    if (apb_req.paddr == OWC_OFS_CTRL)
    begin
      next_rdata[OWC_CTRL_SEL]       = sel;
      next_rdata[OWC_CTRL_DIV_LO +: 2] = div;
      next_rdata[OWC_CTRL_ABORT]     = abort;
      next_rdata[OWC_CTRL_BUSY]      = soft_act;
    end
    else if (apb_req.paddr == OWC_OFS_CMP)
    begin
      next_rdata[7:0] = cmp;
    end
    else if (apb_req.paddr == OWC_OFS_SYS1)
    begin
      next_rdata[OWC_SYS1_STOP] = stop_req;
    end
    else if (apb_req.paddr == OWC_OFS_SYS2)
    begin
      next_rdata[OWC_SYS2_FEN]   = fast_en;
      next_rdata[OWC_SYS2_SEN]   = slow_en;
      next_rdata[OWC_SYS2_SYSCK] = sysck;
    end
    else if (apb_req.paddr == OWC_OFS_STAT)
    begin
      next_rdata[OWC_CNT_W-1:0] = cnt;
      next_rdata[17:16]         = phase;
    end
    else
    begin
      next_err = 1'b1;                                              // Unmapped
    end
  end

  // Read data and error captured at setup, shown in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apb_rsp.prdata  <= '0;
      apb_rsp.pslverr <= 1'b0;
      apb_rsp.pready  <= 1'b1;                                      // Zero wait states, held high
    end
    else if (setup)
    begin
      apb_rsp.prdata  <= apb_req.pwrite ? 32'h0000_0000 : next_rdata;
      apb_rsp.pslverr <= next_err;
    end
  end

endmodule

// ---- tb/owc_top_asserts.sv ----
// Port checker for the warm-up counter block
`timescale 1ns/1ps

module owc_top_asserts
  import owc_pkg::*;
(
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // Bus
  input wire owc_pkg::owc_apb_req_t apb_req,
  input wire owc_pkg::owc_apb_rsp_t apb_rsp,
  // Chip controls
  input wire owc_pkg::owc_sys_out_t sys_out,
  input wire owc_pkg::owc_mode_t    op_mode,
  input wire logic                  warmup_done_irq,
  input wire logic                  stop_resume
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic mapped; // Address hits a register
  assign mapped = apb_req.paddr inside {OWC_OFS_CTRL, OWC_OFS_CMP, OWC_OFS_SYS1,
                                        OWC_OFS_SYS2, OWC_OFS_STAT};
  // Setup cycle of a transfer
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  // Completing write to a given offset
  sequence s_write(logic [7:0] ofs);
    apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == ofs;
  endsequence
  property p_ready;
    apb_rsp.pready;
  endproperty
  property p_err_bad;
    s_setup ##0 !mapped |=> apb_rsp.pslverr;
  endproperty
  property p_err_ok;
    s_setup ##0 mapped |=> !apb_rsp.pslverr;
  endproperty
  property p_irq_pulse;
    warmup_done_irq |=> !warmup_done_irq;
  endproperty
  property p_resume_pulse;
    stop_resume |=> !stop_resume;
  endproperty
  property p_core_hold;
    sys_out.core_reset_n |=> sys_out.core_reset_n;
  endproperty
  property p_irq_core;
    warmup_done_irq |-> sys_out.core_reset_n;
  endproperty
  property p_abort_en;
    s_write(OWC_OFS_CTRL) ##0 apb_req.pwdata[OWC_CTRL_ABORT] |=>
      $stable(sys_out.fast_osc_enable) && $stable(sys_out.slow_osc_enable);
  endproperty
  property p_single_gpio;
    (op_mode == OWC_SINGLE_OSC_NORMAL) [*3] |-> sys_out.slow_pins_gpio;
  endproperty
  property p_stop_entry;
    s_write(OWC_OFS_SYS1) ##0 apb_req.pwdata[OWC_SYS1_STOP] && sys_out.core_reset_n
      && op_mode != OWC_STOP |-> ##[1:3] op_mode == OWC_STOP;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_err_bad: assert property (p_err_bad) else $error("no error on unmapped");
  a_err_ok: assert property (p_err_ok) else $error("error on mapped");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  a_resume_pulse: assert property (p_resume_pulse) else $error("resume too long");
  a_core_hold: assert property (p_core_hold) else $error("core reset again");
  a_irq_core: assert property (p_irq_core) else $error("irq in reset");
  a_abort_en: assert property (p_abort_en) else $error("abort moved enable");
  a_single_gpio: assert property (p_single_gpio) else $error("pins not free");
  a_stop_entry: assert property (p_stop_entry) else $error("no stop");
endmodule

bind owc_top owc_top_asserts owc_top_asserts_i (
  .pclk            (pclk),
  .presetn         (presetn),
  .apb_req         (apb_req),
  .apb_rsp         (apb_rsp),
  .sys_out         (sys_out),
  .op_mode         (op_mode),
  .warmup_done_irq (warmup_done_irq),
  .stop_resume     (stop_resume)
);

// ---- tb/owc_osc_model.sv ----
// Oscillator stand-in that runs only while enabled
`timescale 1ns/1ps

module owc_osc_model #(
  parameter int HALF = 3 // Half period in pclk cycles
) (
  // Clock and enable
  input  wire logic pclk,
  input  wire logic enable,
  // Oscillator output
  output logic      osc
);
  int cnt; // Cycles since last toggle
  // Stopped oscillator stands still low
  always @(posedge pclk)
  begin
    if (!enable)
    begin
      osc <= 1'b0;
      cnt <= 0;
    end
    else if (cnt == HALF - 1)
    begin
      osc <= ~osc;
      cnt <= 0;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

// ---- tb/owc_top_test.sv ----
// Self-checking bench for the warm-up counter block
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

module owc_top_test;
  import owc_pkg::*;
  logic         pclk;
  logic         presetn;
  owc_apb_req_t req;
  owc_apb_rsp_t rsp;
  logic         hfc;
  logic         lfc;
  logic         stop_release;
  owc_sys_out_t sys_out;
  owc_mode_t    op_mode;
  logic         irq;
  logic         resume;
  int           miscompares;
  int           comparisons;
  int           cyc; // Free cycle count

  owc_top owc_top_i (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .high_freq_clock(hfc), .low_freq_clock(lfc), .stop_release(stop_release),
    .sys_out(sys_out), .op_mode(op_mode), .warmup_done_irq(irq), .stop_resume(resume));
  // Fast and slow oscillators
  owc_osc_model #(.HALF(3)) owc_osc_model_i (.pclk(pclk),
    .enable(sys_out.fast_osc_enable), .osc(hfc));
  owc_osc_model #(.HALF(10)) owc_osc_model_s_i (.pclk(pclk),
    .enable(sys_out.slow_osc_enable), .osc(lfc));

  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk)
    cyc <= cyc + 1;

  // One bus transfer, held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    do
      @(posedge pclk);
    while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                    input string nm);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    `CHK(nm, x, r & m)
  endtask
  // Bounded wait for irq or resume pulse
  task automatic wt(input bit rs);
    int n;
    n = 0;
    while ((rs ? resume : irq) !== 1'b1 && n < 20000)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  function automatic bit near(int n, int e);
    return n > e - 40 && n < e + 40;
  endfunction

  task automatic t_reset;
    int t0;
    t0 = cyc;
    `CHK("core held", 1'b0, sys_out.core_reset_n)
    rd(OWC_OFS_CTRL, 32'h1f, {29'h0, OWC_RST_DIV, OWC_RST_SEL}, "ctrl");
    rd(OWC_OFS_CMP, 32'hff, 32'(OWC_RST_CMP), "cmp");
    wr(OWC_OFS_CMP, 32'h1);
    while (sys_out.core_reset_n !== 1'b1 && cyc - t0 < 9000)
      @(posedge pclk);
    `CHK("reset warm", 1'b1, near(cyc - t0, 3072))
    rd(OWC_OFS_STAT, 32'h3ffff, 32'h10000, "stat");
    `CHK("mode", OWC_SINGLE_OSC_NORMAL, op_mode)
    $display("t_reset done");
  endtask

  task automatic t_div;
    int t0;
    for (int d = 0; d < 4; d++)
    begin
      wr(OWC_OFS_SYS2, 32'h1);
      wr(OWC_OFS_CTRL, 32'h1 | 32'(d << OWC_CTRL_DIV_LO));
      t0 = cyc;
      wr(OWC_OFS_SYS2, 32'h3);
      wt(1'b0);
      `CHK("sw time", 1'b1, near(cyc - t0, (64 << d) * 20))
      rd(OWC_OFS_CTRL, 32'h10, 32'h0, "busy");
      rd(OWC_OFS_STAT, 32'h3fff, 32'h0, "count");
      `CHK("dual", OWC_DUAL_OSC_NORMAL, op_mode)
    end
    $display("t_div done");
  endtask

  task automatic t_abort;
    logic [31:0] r;
    logic        e;
    wr(OWC_OFS_SYS2, 32'h1);
    wr(OWC_OFS_SYS2, 32'h3);
    repeat (200) @(posedge pclk);
    rd(OWC_OFS_CTRL, 32'h10, 32'h10, "busy on");
    wr(OWC_OFS_CTRL, 32'h9);
    rd(OWC_OFS_CTRL, 32'h18, 32'h0, "aborted");
    rd(OWC_OFS_STAT, 32'h3fff, 32'h0, "cleared");
    rd(OWC_OFS_SYS2, 32'h3, 32'h3, "enables");
    wr(OWC_OFS_SYS2, 32'h3);
    repeat (200) @(posedge pclk);
    rd(OWC_OFS_CTRL, 32'h10, 32'h0, "no restart");
    xfer(1'b0, 8'h40, 32'h0, r, e);
    `CHK("unmapped", 1'b1, e)
    $display("t_abort done");
  endtask

  task automatic t_stop;
    int t0;
    wr(OWC_OFS_CTRL, 32'h7);
    wr(OWC_OFS_CMP, 32'h1);
    wr(OWC_OFS_SYS1, 32'h1);
    repeat (4) @(posedge pclk);
    `CHK("stop", OWC_STOP, op_mode)
    stop_release <= 1'b1;
    t0 = cyc;
    repeat (4) @(posedge pclk);
    stop_release <= 1'b0;
    wt(1'b1);
    `CHK("stop warm", 1'b1, near(cyc - t0, 3072))
    rd(OWC_OFS_SYS1, 32'h1, 32'h0, "resumed");
    `CHK("mode back", OWC_DUAL_OSC_NORMAL, op_mode)
    $display("t_stop done");
  endtask

  // Low-speed modes and a fast-oscillator start counted on the fast clock
  task automatic t_fast;
    int t0;
    wr(OWC_OFS_SYS2, 32'h6);
    wr(OWC_OFS_CTRL, 32'h0);
    repeat (4) @(posedge pclk);
    `CHK("fast off", OWC_LOW_SPEED_FAST_OFF, op_mode)
    `CHK("main slow", 1'b1, sys_out.main_clk_slow)
    t0 = cyc;
    wr(OWC_OFS_SYS2, 32'h7);
    wt(1'b0);
    `CHK("fast time", 1'b1, near(cyc - t0, 64 * 6))
    `CHK("fast on", OWC_LOW_SPEED_FAST_ON, op_mode)
    `CHK("pins osc", 1'b0, sys_out.slow_pins_gpio)
    $display("t_fast done");
  endtask

  task automatic results;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    presetn = 1'b0;
    req = '0;
    stop_release = 1'b0;
    cyc = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_div;
    t_abort;
    t_stop;
    t_fast;
    results;
  end
  // Watchdog
  initial
  begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    results;
  end
endmodule
